// ==== hw/arcs_pkg.sv ====
// constants and types of the converter result/compare block
package arcs_pkg;
  localparam int RES_W = 10;
  localparam int THR_W = 8;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFF_MODE0 = 8'h00;
  localparam logic [7:0] OFF_CHSEL = 8'h04;
  localparam logic [7:0] OFF_CMPMODE = 8'h08;
  localparam logic [7:0] OFF_THRESH = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_RESULT = 8'h40;
  localparam logic [7:0] OFF_RESULT_HI = 8'h80;
  // field positions
  localparam int MODE0_EN_BIT = 0;
  localparam int CMP_EN_BIT = 0;
  localparam int CMP_COND_BIT = 1;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_W = 1;
  // reset values
  localparam logic MODE0_RST = 1'b0;
  localparam logic [1:0] CMPMODE_RST = 2'h0;
  localparam logic [THR_W-1:0] THRESH_RST = 8'h00;
  localparam logic [STAT_W-1:0] MASK_RST = 1'h0;
  localparam logic [RES_W-1:0] RESULT_RST = 10'h000;

  // one finished conversion from the analogue front end
  typedef struct packed {
    logic valid;
    logic [RES_W-1:0] data;
  } arcs_conv_t;

  // compare settings handed to the comparator
  typedef struct packed {
    logic enable;
    logic cond_below;
    logic [THR_W-1:0] threshold;
  } arcs_cmp_cfg_t;
endpackage

// ==== hw/arcs_cmp.sv ====
// threshold comparator for one finished conversion
`timescale 1ns/1ps
module arcs_cmp (
  input arcs_pkg::arcs_cmp_cfg_t cfg,
  input wire logic [arcs_pkg::RES_W-1:0] data,
  output logic accept
);
  import arcs_pkg::*;
  logic [THR_W-1:0] hi_byte;
  logic hit;

  // high byte of the fresh result against the threshold
  assign hi_byte = data[RES_W-1 -: THR_W];
  assign hit = cfg.cond_below ? (hi_byte < cfg.threshold)
                              : (hi_byte >= cfg.threshold);
  // compare off lets every result through
  assign accept = cfg.enable ? hit : 1'b1;
endmodule

// ==== hw/arcs_top.sv ====
// converter result store, select-mode compare and apb register file
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module arcs_top #(
  parameter int N_CH = 8,
  parameter int SEL_W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [arcs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input arcs_pkg::arcs_conv_t conv,
  output logic conv_enable,
  output logic [SEL_W-1:0] conv_channel,
  output logic conv_restart,
  output logic conversion_done_irq
);
  import arcs_pkg::*;

  logic mode_en_r;
  logic [SEL_W-1:0] chsel_r;
  logic [1:0] cmpmode_r;
  logic [THR_W-1:0] thresh_r;
  logic [STAT_W-1:0] status_r;
  logic [STAT_W-1:0] status_nxt;
  logic [STAT_W-1:0] mask_r;
  logic [STAT_W-1:0] mask_nxt;
  logic [RES_W-1:0] result_r [N_CH];
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic irq_r;
  logic restart_r;
  logic [31:0] rdata_nxt;
  logic hit_map;
  logic acc;
  logic wr;
  logic rd;
  logic cfg_wr;
  logic accept;
  logic store;
  arcs_cmp_cfg_t cfg;

  // access phase completes on the second cycle of penable
  assign acc = psel && penable && pready_r;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  // writes that disturb a conversion in flight
  assign cfg_wr = wr && (paddr == OFF_MODE0 || paddr == OFF_CHSEL);

  assign cfg.enable = cmpmode_r[CMP_EN_BIT];
  assign cfg.cond_below = cmpmode_r[CMP_COND_BIT];
  assign cfg.threshold = thresh_r;

  arcs_cmp u_cmp (
    .cfg(cfg),
    .data(conv.data),
    .accept(accept)
  );

  // a result landing with a mode or select write is dropped, so the old
  // value stays; software must read before reconfiguring
  assign store = conv.valid && mode_en_r && accept && !cfg_wr;

  // one wait state keeps prdata and pready straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= psel && penable && !pready_r;
    end
  end

  // read data and error captured as pready rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (psel && penable && !pready_r) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rdata_nxt;
      pslverr_r <= !hit_map;
    end
  end

  // address decode, reserved bits read as zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    hit_map = 1'b1;
    if (paddr[1:0] != 2'b00) begin
      hit_map = 1'b0;
    end else if (paddr >= OFF_RESULT &&
                 paddr < OFF_RESULT + ADDR_W'(4 * N_CH)) begin
      rdata_nxt[RES_W-1:0] = result_r[paddr[SEL_W+1:2]];
    end else if (paddr >= OFF_RESULT_HI &&
                 paddr < OFF_RESULT_HI + ADDR_W'(4 * N_CH)) begin
      rdata_nxt[THR_W-1:0] =
        result_r[paddr[SEL_W+1:2]][RES_W-1 -: THR_W];
    end else begin
      unique case (paddr)
        OFF_MODE0: rdata_nxt[MODE0_EN_BIT] = mode_en_r;
        OFF_CHSEL: rdata_nxt[SEL_W-1:0] = chsel_r;
        OFF_CMPMODE: rdata_nxt[1:0] = cmpmode_r;
        OFF_THRESH: rdata_nxt[THR_W-1:0] = thresh_r;
        OFF_STATUS: rdata_nxt[STAT_W-1:0] = status_r;
        OFF_MASK: rdata_nxt[STAT_W-1:0] = mask_r;
        default: hit_map = 1'b0;
      endcase
    end
  end

  // converter enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_en_r <= MODE0_RST;
    end else if (wr && paddr == OFF_MODE0) begin
      mode_en_r <= pwdata[MODE0_EN_BIT];
    end
  end

  // channel select; a change also restarts the conversion in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chsel_r <= '0;
    end else if (wr && paddr == OFF_CHSEL) begin
      chsel_r <= pwdata[SEL_W-1:0];
    end
  end

  // compare enable and compare condition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpmode_r <= CMPMODE_RST;
    end else if (wr && paddr == OFF_CMPMODE) begin
      cmpmode_r <= pwdata[1:0];
    end
  end

  // compare threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thresh_r <= THRESH_RST;
    end else if (wr && paddr == OFF_THRESH) begin
      thresh_r <= pwdata[THR_W-1:0];
    end
  end

  // next mask, shared with the interrupt flop so that a mask write and
  // the interrupt output move together instead of one cycle apart
  always_comb begin
    mask_nxt = mask_r;
    if (wr && paddr == OFF_MASK) begin
      mask_nxt = pwdata[STAT_W-1:0];
    end
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= MASK_RST;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // the front end restarts after a mode or select write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_r <= 1'b0;
    end else begin
      restart_r <= cfg_wr;
    end
  end

  // only the selected channel's register is written
  for (genvar i = 0; i < N_CH; i++) begin : g_res
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        result_r[i] <= RESULT_RST;
      end else if (store && chsel_r == SEL_W'(i)) begin
        result_r[i] <= conv.data;
      end
    end
  end

  // sticky done flag: a read clears only the bits it returned, so an
  // event landing between data capture and the end of the read is kept;
  // an event in the clearing cycle itself wins over the clear
  always_comb begin
    status_nxt = status_r;
    if (rd && paddr == OFF_STATUS) begin
      status_nxt = status_r & ~prdata_r[STAT_W-1:0];
    end
    if (store) begin
      status_nxt[STAT_DONE_BIT] = 1'b1;
    end
  end

  // done status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // level interrupt from a flop, high while an unmasked bit is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_nxt & mask_nxt);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign conv_enable = mode_en_r;
  assign conv_channel = chsel_r;
  assign conv_restart = restart_r;
  assign conversion_done_irq = irq_r;
endmodule

// ==== bench/arcs_top_checker.sv ====
// port assertions of the converter result/compare block
`timescale 1ns/1ps
module arcs_top_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [arcs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input arcs_pkg::arcs_conv_t conv,
  input wire logic conv_enable,
  input wire logic conv_restart,
  input wire logic conversion_done_irq
);
  import arcs_pkg::*;
  logic [10:0] c_r;
  wire wr = psel && penable && pready && pwrite;
  // writes are excluded so a mask or mode change never blurs the cause
  wire tk = conv.valid && conv_enable && !wr;
  wire hok = c_r[9] ? conv.data[9:2] < c_r[7:0] : conv.data[9:2] >= c_r[7:0];
  // mirror of compare setup (bits 9:0) and mask (bit 10)
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) c_r <= 11'h000;
    else if (wr && paddr == OFF_CMPMODE) c_r[9:8] <= pwdata[1:0];
    else if (wr && paddr == OFF_THRESH) c_r[7:0] <= pwdata[7:0];
    else if (wr && paddr == OFF_MASK) c_r[10] <= pwdata[0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_restart_pulse: assert property (
    wr && (paddr == OFF_MODE0 || paddr == OFF_CHSEL) |=> conv_restart)
    else $error("no restart after reconfig");
  chk_equal_hits: assert property (
    tk && c_r[8] && !c_r[9] && conv.data[9:2] == c_r[7:0] && c_r[10]
    |=> conversion_done_irq) else $error("equal high byte missed");
  chk_hit_irq: assert property (
    tk && c_r[8] && hok && c_r[10] |=> conversion_done_irq)
    else $error("match without irq");
  chk_miss_quiet: assert property (
    tk && c_r[8] && !hok && !conversion_done_irq |=> !conversion_done_irq)
    else $error("irq on miss");
  chk_off_irq: assert property (
    tk && !c_r[8] && c_r[10] |=> conversion_done_irq)
    else $error("no irq with compare off");
endmodule

// ==== bench/arcs_cpu.sv ====
// cpu-side bus master model issuing register transfers
`timescale 1ns/1ps
module arcs_cpu (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  logic err = 1'b0;
  logic hung = 1'b0;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // model runs on the main clock only, so result reads are legal
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) begin
      hung = 1'b1;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // released data must not look valid
    // one idle edge, so a following call never re-drives in this step
    @(posedge pclk);
  endtask
endmodule

// ==== bench/arcs_top_tb.sv ====
// self-checking bench of the converter result/compare block
`timescale 1ns/1ps
module arcs_top_tb;
  import arcs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ex;
  logic conv_enable, conv_restart, conversion_done_irq;
  logic [7:0] paddr, thr;
  logic [31:0] pwdata, prdata, q, d, s = 32'h18ab;
  logic [2:0] conv_channel;
  logic [9:0] res [8] = '{default: 10'h000};
  arcs_conv_t conv;
  int miscompares, checks_done, i;
  arcs_top DUT (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .conv(conv),
    .conv_enable(conv_enable),
    .conv_channel(conv_channel),
    .conv_restart(conv_restart),
    .conversion_done_irq(conversion_done_irq)
  );
  arcs_cpu cpu (
    .pclk(pclk),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata)
  );
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // store decision: compare off, or high byte meets the condition
  function automatic logic hit(logic [1:0] m, logic [7:0] t, logic [7:0] h);
    return !m[0] || (m[1] ? h < t : h >= t);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // run limit; a bus wait that gives up ends the run here as well
  initial begin
    for (int t = 0; t < 20000 && !cpu.hung; t++) begin
      @(posedge pclk);
    end
    miscompares++;
    end_sim();
  end
  initial begin
    presetn = 1'b0;
    conv = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cpu.xfer(1, OFF_MODE0, 32'h1, q);
    chk(conv_enable, 1);
    // first eight rounds run with compare off, the rest with it on
    for (i = 0; i < 40; i++) begin
      d = rnd();
      thr = i % 4 == 1 ? d[21:14] : d[11:4]; // equal high byte corner
      cpu.xfer(1, OFF_CMPMODE, {30'h0, d[3], i > 7}, q);
      cpu.xfer(1, OFF_THRESH, {24'h0, thr}, q);
      cpu.xfer(1, OFF_MASK, {31'h0, i != 5}, q);
      cpu.xfer(1, OFF_CHSEL, {29'h0, d[2:0]}, q);
      @(posedge pclk);
      chk(conv_channel, d[2:0]);
      conv <= '{1'b1, d[21:12]};
      @(posedge pclk);
      conv <= '0;
      ex = hit({d[3], i > 7}, thr, d[21:14]);
      if (ex) res[d[2:0]] = d[21:12];
      @(posedge pclk);
      chk(conversion_done_irq, ex && i != 5);
      cpu.xfer(0, OFF_RESULT | {3'h0, d[2:0], 2'h0}, 0, q);
      chk(q, res[d[2:0]]);
      chk(cpu.err, 0);
      cpu.xfer(0, OFF_RESULT_HI | {3'h0, d[2:0], 2'h0}, 0, q);
      chk(q, res[d[2:0]][9:2]);
      cpu.xfer(0, OFF_STATUS, 0, q);
      chk(q, ex);
      @(posedge pclk);
      chk(conversion_done_irq, 0);
    end
    // a result landing with a select write is dropped
    d = rnd();
    cpu.xfer(1, OFF_CMPMODE, 32'h0, q);
    fork
      cpu.xfer(1, OFF_CHSEL, {29'h0, d[2:0]}, q);
      begin
        repeat (2) @(posedge pclk);
        conv <= '{1'b1, d[21:12]};
        @(posedge pclk);
        conv <= '0;
      end
    join
    @(posedge pclk);
    chk(conversion_done_irq, 0);
    cpu.xfer(0, OFF_RESULT | {3'h0, d[2:0], 2'h0}, 0, q);
    chk(q, res[d[2:0]]);
    // a result while the converter is off is dropped
    cpu.xfer(1, OFF_MODE0, 32'h0, q);
    chk(conv_enable, 0);
    conv <= '{1'b1, ~d[21:12]};
    @(posedge pclk);
    conv <= '0;
    @(posedge pclk);
    chk(conversion_done_irq, 0);
    cpu.xfer(0, OFF_STATUS, 0, q);
    chk(q, 0);
    cpu.xfer(0, OFF_RESULT | {3'h0, d[2:0], 2'h0}, 0, q);
    chk(q, res[d[2:0]]);
    // misaligned read is refused with an error and zero data
    cpu.xfer(0, OFF_RESULT | 8'h01, 0, q);
    chk(q, 0);
    chk(cpu.err, 1);
    end_sim();
  end
endmodule
bind arcs_top arcs_top_checker chk_u (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pready(pready),
  .conv(conv),
  .conv_enable(conv_enable),
  .conv_restart(conv_restart),
  .conversion_done_irq(conversion_done_irq)
);
